// ---- bench/lfp_ctrl_sva.sv ----
// Port-level checker for the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module lfp_ctrl_sva #(
	parameter int MAX_ON_CYC = 40,
	parameter int MAX_OFF_CYC = 60
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Fault inputs
	input wire logic supply_overvoltage_in,
	input wire logic over_temp_in,
	input wire logic regulation_ovp_in,
	// Outputs
	input wire logic gate_drive_out,
	input wire logic [7:0] current_limit_code,
	input wire logic latched_off,
	input wire logic auto_restart
);
	int on_n;
	int off_n;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Counters instead of long repetitions
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			on_n <= 0;
			off_n <= 0;
		end else begin
			on_n <= gate_drive_out ? on_n + 1 : 0;
			off_n <= (gate_drive_out || auto_restart || latched_off) ? 0 : off_n + 1;
		end
	end
	chk_on_bound: assert property (on_n <= MAX_ON_CYC + 1)
		else $error("gate high beyond max on-time");
	chk_off_bound: assert property (off_n <= MAX_OFF_CYC + 2)
		else $error("gate low beyond max off-time");
	chk_blank_min: assert property ($rose(gate_drive_out) |=>
		(gate_drive_out || auto_restart || latched_off) [*2])
		else $error("pulse ended inside blanking");
	chk_ring_gap: assert property ($fell(gate_drive_out) |=> !gate_drive_out [*6])
		else $error("turn-on during ringing suppression");
	chk_latch_gate: assert property (latched_off |-> !gate_drive_out)
		else $error("gate on while latched");
	chk_latch_keep: assert property (latched_off |=> latched_off)
		else $error("latched mode left without reset");
	chk_restart_gate: assert property (auto_restart |-> !gate_drive_out)
		else $error("gate on during auto-restart");
	chk_temp_stop: assert property (over_temp_in |=>
		!gate_drive_out && (auto_restart || latched_off))
		else $error("over-temperature not acted on");
	chk_reg_stop: assert property (regulation_ovp_in |=>
		!gate_drive_out && (auto_restart || latched_off))
		else $error("regulation overvoltage not acted on");
	chk_supply_stop: assert property (supply_overvoltage_in |=> !gate_drive_out)
		else $error("supply overvoltage not acted on");
	chk_limit_span: assert property (current_limit_code >= lfp_pkg::LIM_SS_FIRST
		&& current_limit_code <= lfp_pkg::LIM_FULL)
		else $error("current limit out of range");
endmodule : lfp_ctrl_sva
bind lfp_ctrl lfp_ctrl_sva #(.MAX_ON_CYC(MAX_ON_CYC), .MAX_OFF_CYC(MAX_OFF_CYC)) u_sva (
	.ref_clk, .resetn, .supply_overvoltage_in, .over_temp_in, .regulation_ovp_in,
	.gate_drive_out, .current_limit_code, .latched_off, .auto_restart);
`default_nettype wire

// ---- bench/lfp_sw_model.sv ----
// Switch, sense resistor and auxiliary winding model
`timescale 1ns/1ps
`default_nettype none
module lfp_sw_model (
	// Clock and gate
	input wire logic ref_clk,
	input wire logic gate_drive_out,
	// Ramp and ringing lengths in cycles
	input wire logic [15:0] on_len,
	input wire logic [15:0] off_len,
	// Comparator levels
	output logic current_sense_cmp_in,
	output logic zero_cross_in
);
	logic g;
	int n;
	initial begin
		g = 1'h0;
		n = 0;
		current_sense_cmp_in = 1'h0;
		zero_cross_in = 1'h0;
	end
	// Falling edge, so the design samples settled levels
	always @(negedge ref_clk) begin
		n = (gate_drive_out === g) ? n + 1 : 1;
		g = gate_drive_out;
		current_sense_cmp_in <= g && n >= on_len;
		zero_cross_in <= !g && n >= off_len;
	end
endmodule : lfp_sw_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 0, resetn = 0, supply_below_off_in = 0, supply_above_on_in = 0;
	logic supply_overvoltage_in = 0, over_temp_in = 0, regulation_ovp_in = 0, valley_ovp_in = 0;
	logic short_winding_cmp_in = 0, current_sense_cmp_in, zero_cross_in;
	logic [7:0] valley_current_in = 8'h00, current_limit_code, lf = 8'h46;
	logic gate_drive_out, startup_charge_en, latched_off, auto_restart;
	logic [15:0] on_len = 16'h0001, off_len = 16'h000F;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	// On and off limits keep their real defaults so those timers run as built
	lfp_ctrl #(.LEB_CYC(4), .SW_BLANK_CYC(4), .OVP_BLANK_CYC(4), .RING_CYC(8),
		.SS_STEP_CYC(50)) uut (.*);
	lfp_sw_model sw (.ref_clk, .gate_drive_out, .on_len, .off_len, .current_sense_cmp_in,
		.zero_cross_in);
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic wait_gate(input logic v);
		for (int i = 0; i < 200 && gate_drive_out !== v; i++) tick(1);
	endtask : wait_gate
	// Limit from soft-start step and valley current
	function automatic int lim_exp(input int s, input int iz);
		int ss, ex, f;
		ss = s >= 4 ? 100 : 32 + 17 * s;
		ex = iz > 50 ? iz - 50 : 0;
		f = 100 - (ex < 16 ? ex : 16 + (ex - 16) / 2);
		f = f < 66 ? 66 : f;
		return ss < f ? ss : f;
	endfunction : lim_exp
	task automatic boot();
		supply_below_off_in = 1;
		tick(3);
		chk(startup_charge_en, 1'h1);
		supply_below_off_in = 0;
		supply_above_on_in = 1;
		tick(2);
		chk(startup_charge_en, 1'h0);
		chk(current_limit_code, 8'h20);
		supply_above_on_in = 0;
	endtask : boot
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		tick(12);
		chk({gate_drive_out, latched_off, auto_restart}, 3'h0);
		resetn = 1;
		tick(2);
		boot();
		// Early sense trip exercises blanking
		tick(23);
		for (int s = 0; s < 5; s++) begin
			chk(current_limit_code, lim_exp(s, 0));
			tick(50);
		end
		$display("soft-start done");
		repeat (8) begin
			lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
			valley_current_in = lf;
			tick(4);
			chk(current_limit_code, lim_exp(4, lf));
		end
		$display("foldback done");
		on_len = 16'h0014;
		wait_gate(1);
		tick(23);
		chk(gate_drive_out, 1'h0);
		on_len = 16'h1F40;
		wait_gate(1);
		tick(3005);
		chk(gate_drive_out, 1'h0);
		off_len = 16'h1F40;
		wait_gate(0);
		tick(5004);
		chk(gate_drive_out, 1'h1);
		on_len = 16'h0014;
		off_len = 16'h000F;
		$display("timing done");
		for (int k = 0; k < 3; k++) begin
			{supply_overvoltage_in, over_temp_in, regulation_ovp_in} = 3'h1 << k;
			tick(2);
			chk({auto_restart, gate_drive_out}, 2'h2);
			{supply_overvoltage_in, over_temp_in, regulation_ovp_in} = 3'h0;
			boot();
		end
		$display("auto-restart done");
		wait_gate(1);
		short_winding_cmp_in = 1;
		tick(2);
		short_winding_cmp_in = 0;
		tick(2);
		chk(latched_off, 1'h0);
		short_winding_cmp_in = 1;
		tick(10);
		short_winding_cmp_in = 0;
		chk({latched_off, gate_drive_out}, 2'h2);
		supply_below_off_in = 1;
		tick(2);
		chk(startup_charge_en, 1'h1);
		supply_below_off_in = 0;
		supply_above_on_in = 1;
		tick(2);
		chk({latched_off, startup_charge_en}, 2'h2);
		supply_above_on_in = 0;
		resetn = 0;
		tick(2);
		resetn = 1;
		tick(2);
		boot();
		wait_gate(1);
		wait_gate(0);
		valley_ovp_in = 1;
		tick(2);
		valley_ovp_in = 0;
		chk(latched_off, 1'h0);
		wait_gate(1);
		wait_gate(0);
		valley_ovp_in = 1;
		tick(8);
		valley_ovp_in = 0;
		chk(latched_off, 1'h1);
		$display("latch done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire

// ---- core/lfp_ctrl.sv ----
// Flyback LED controller protection and current-limit sequencer
// Overview of operation
// - Sense above active limit ends gate pulse
// - Ignore current comparator during leading-edge blanking
// - Short-winding comparator needs persistence beyond blanking
// - Current limit falls as bus voltage rises
// - Excess valley current over step threshold sets offset
// - Supply under/over voltage resets, gate held off
// - Charge below off threshold, restart with soft-start
// - Output overvoltage during off-time latches off after blank
// - Regulation overvoltage stops switching, auto-restart
// - Over-temperature above 140 C stops, auto-restart
// - Short-winding during on-time latches off
// - Latched off charges between 10.5 and 18 V
// - Gate forced low after max on-time
// - Soft-start raises limit in four steps over 12ms
// - No turn-on during ringing suppression, then zero crossing
// - Turn on anyway after max off-time
`timescale 1ns/1ps
`default_nettype none
module lfp_ctrl #(
	parameter int LEB_CYC = lfp_pkg::LEB_CYC,
	parameter int SW_BLANK_CYC = lfp_pkg::SW_BLANK_CYC,
	parameter int OVP_BLANK_CYC = lfp_pkg::OVP_BLANK_CYC,
	parameter int RING_CYC = lfp_pkg::RING_CYC,
	parameter int MAX_ON_CYC = lfp_pkg::MAX_ON_CYC,
	parameter int MAX_OFF_CYC = lfp_pkg::MAX_OFF_CYC,
	parameter int SS_STEP_CYC = lfp_pkg::SS_STEP_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Supply monitor comparators
	input wire logic supply_below_off_in,
	input wire logic supply_above_on_in,
	input wire logic supply_overvoltage_in,
	// Protection comparators
	input wire logic over_temp_in,
	input wire logic regulation_ovp_in,
	input wire logic valley_ovp_in,
	input wire logic short_winding_cmp_in,
	// Switching comparators
	input wire logic current_sense_cmp_in,
	input wire logic zero_cross_in,
	// Digitised valley-pin current, same scale as limit codes
	input wire logic [7:0] valley_current_in,
	// Outputs
	output logic gate_drive_out,
	output logic startup_charge_en,
	output logic [7:0] current_limit_code,
	output logic latched_off,
	output logic auto_restart
);
	lfp_pkg::lfp_state_e state;
	lfp_pkg::lfp_state_e next_state;
	logic [lfp_pkg::CNT_W-1:0] on_cnt;
	logic [lfp_pkg::CNT_W-1:0] off_cnt;
	logic [lfp_pkg::CNT_W-1:0] ss_cnt;
	logic [lfp_pkg::CNT_W-1:0] sw_cnt;
	logic [lfp_pkg::CNT_W-1:0] ovp_cnt;
	logic [1:0] ss_step;
	logic ss_done;

	function automatic logic [lfp_pkg::CNT_W-1:0] sat_inc(input logic [lfp_pkg::CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction : sat_inc

	// Soft-start ceiling and foldback offset
	wire [7:0] ss_limit = ss_done ? lfp_pkg::LIM_FULL
		: 8'(lfp_pkg::LIM_SS_FIRST + 8'(ss_step) * lfp_pkg::LIM_SS_STEP);
	wire [7:0] fold_excess = (valley_current_in > lfp_pkg::FOLD_FIRST_STEP)
		? 8'(valley_current_in - lfp_pkg::FOLD_FIRST_STEP) : 8'h00;
	// Nonlinear curve: steep first, then half slope, floored at minimum
	wire [7:0] fold_offset = (fold_excess < 8'h10) ? fold_excess
		: 8'(8'h10 + ((fold_excess - 8'h10) >> 1));
	wire [7:0] fold_limit = (fold_offset >= 8'(lfp_pkg::LIM_FULL - lfp_pkg::LIM_MIN))
		? lfp_pkg::LIM_MIN : 8'(lfp_pkg::LIM_FULL - fold_offset);
	wire [7:0] next_limit = (ss_limit < fold_limit) ? ss_limit : fold_limit;

	// Fault decode
	wire supply_fault = supply_below_off_in | supply_overvoltage_in;
	wire restart_fault = supply_fault | regulation_ovp_in | over_temp_in;
	wire running = (state == lfp_pkg::LFP_RUN);
	wire sw_fire = gate_drive_out & short_winding_cmp_in
		& (sw_cnt >= 24'(SW_BLANK_CYC));
	wire ovp_fire = ~gate_drive_out & valley_ovp_in
		& (ovp_cnt >= 24'(OVP_BLANK_CYC));
	wire latch_fault = running & (sw_fire | ovp_fire);

	// Gate decisions
	wire cs_trip = current_sense_cmp_in & (on_cnt >= 24'(LEB_CYC));
	wire on_expired = on_cnt >= 24'(MAX_ON_CYC);
	wire gate_off = cs_trip | on_expired | restart_fault | latch_fault;
	wire ring_over = off_cnt >= 24'(RING_CYC);
	wire off_expired = off_cnt >= 24'(MAX_OFF_CYC);
	wire gate_on = running & ~gate_drive_out & ~restart_fault & ~latch_fault
		& ((ring_over & zero_cross_in) | off_expired);

	always_comb begin
		next_state = state;
		case (state)
			lfp_pkg::LFP_OFF: begin
				if (supply_below_off_in)
					next_state = lfp_pkg::LFP_CHARGE;
			end
			lfp_pkg::LFP_CHARGE: begin
				if (supply_above_on_in & ~supply_overvoltage_in)
					next_state = lfp_pkg::LFP_RUN;
			end
			lfp_pkg::LFP_RUN: begin
				if (latch_fault)
					next_state = lfp_pkg::LFP_LATCH_HIGH;
				else if (restart_fault)
					next_state = supply_below_off_in ? lfp_pkg::LFP_CHARGE
						: lfp_pkg::LFP_OFF;
			end
			lfp_pkg::LFP_LATCH_HIGH: begin
				if (supply_below_off_in)
					next_state = lfp_pkg::LFP_LATCH_LOW;
			end
			lfp_pkg::LFP_LATCH_LOW: begin
				if (supply_above_on_in)
					next_state = lfp_pkg::LFP_LATCH_HIGH;
			end
			default: next_state = lfp_pkg::LFP_OFF;
		endcase
	end

	wire next_charge = (next_state == lfp_pkg::LFP_CHARGE)
		| (next_state == lfp_pkg::LFP_LATCH_LOW);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= lfp_pkg::LFP_OFF;
			startup_charge_en <= 1'b0;
			latched_off <= 1'b0;
			auto_restart <= 1'b0;
			current_limit_code <= lfp_pkg::LIM_SS_FIRST;
		end else begin
			state <= next_state;
			startup_charge_en <= next_charge;
			latched_off <= (next_state == lfp_pkg::LFP_LATCH_HIGH)
				| (next_state == lfp_pkg::LFP_LATCH_LOW);
			auto_restart <= (next_state == lfp_pkg::LFP_OFF)
				| (next_state == lfp_pkg::LFP_CHARGE);
			current_limit_code <= next_limit;
		end
	end

	// Gate flop; turn-off takes priority so a trip is never missed
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			gate_drive_out <= 1'b0;
		else if (gate_off | ~running)
			gate_drive_out <= 1'b0;
		else if (gate_on)
			gate_drive_out <= 1'b1;
	end

	// Interval counters
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			on_cnt <= '0;
			off_cnt <= '0;
			sw_cnt <= '0;
			ovp_cnt <= '0;
		end else begin
			on_cnt <= gate_drive_out ? sat_inc(on_cnt) : '0;
			off_cnt <= gate_drive_out ? '0 : sat_inc(off_cnt);
			sw_cnt <= (gate_drive_out & short_winding_cmp_in) ? sat_inc(sw_cnt) : '0;
			ovp_cnt <= (~gate_drive_out & valley_ovp_in) ? sat_inc(ovp_cnt) : '0;
		end
	end

	// Soft-start restarts whenever switching is not running
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ss_cnt <= '0;
			ss_step <= 2'h0;
			ss_done <= 1'b0;
		end else if (!running) begin
			ss_cnt <= '0;
			ss_step <= 2'h0;
			ss_done <= 1'b0;
		end else if (!ss_done) begin
			if (ss_cnt >= 24'(SS_STEP_CYC - 1)) begin
				ss_cnt <= '0;
				ss_done <= (ss_step == 2'h3);
				ss_step <= 2'(ss_step + 2'h1);
			end else begin
				ss_cnt <= ss_cnt + 1'b1;
			end
		end
	end
endmodule : lfp_ctrl
`default_nettype wire

// ---- core/lfp_pkg.sv ----
// Constants for the flyback protection and current-limit sequencer
package lfp_pkg;
	// Clock period in ns (100 MHz)
	localparam int CLK_PERIOD_NS = 10;
	// Timing figures in their own units
	localparam int LEB_TIME_NS = 330;
	localparam int SHORT_WINDING_BLANK_NS = 190;
	localparam int OVP_BLANK_NS = 1000;
	localparam int RING_SUPPRESS_NS = 2500;
	localparam int MAX_ON_TIME_US = 30;
	localparam int MAX_OFF_TIME_US = 50;
	localparam int SS_TIME_MS = 12;
	localparam int SS_STEPS = 4;
	// Derived cycle counts: least times round up, longest times round down
	localparam int LEB_CYC = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SW_BLANK_CYC = (SHORT_WINDING_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVP_BLANK_CYC = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RING_CYC = (RING_SUPPRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_ON_CYC = (MAX_ON_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int MAX_OFF_CYC = (MAX_OFF_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int SS_STEP_CYC = (SS_TIME_MS * 1000000 / SS_STEPS) / CLK_PERIOD_NS;
	// Current-limit codes, full scale is 1 V at code 100
	localparam int LIM_W = 8;
	localparam logic [7:0] LIM_FULL = 8'h64;
	localparam logic [7:0] LIM_SS_FIRST = 8'h20;
	localparam logic [7:0] LIM_SS_STEP = 8'h11;
	localparam logic [7:0] LIM_MIN = 8'h42;
	localparam logic [7:0] FOLD_FIRST_STEP = 8'h32;
	localparam int CNT_W = 24;
	typedef enum logic [2:0] {
		LFP_OFF = 3'b000,
		LFP_CHARGE = 3'b001,
		LFP_RUN = 3'b010,
		LFP_LATCH_LOW = 3'b011,
		LFP_LATCH_HIGH = 3'b100
	} lfp_state_e;
endpackage : lfp_pkg
